// >>> core/bridge_order.sv
// What this block does
// - memory write and write-invalidate are posted: buffered, done at source first
// - io and config writes get retry and enter the delayed queue
// - delayed write finishes on target bus before initiator sees completion
// - target response of a delayed write is buffered for the initiator side
// - all reads get retry and enter the delayed queue
// - returned read data is buffered and handed to the initiator
// - separate writes are never combined into one
// - byte lanes of separate masked writes are never merged
// - repeated writes to one address are never collapsed
// - ordering position is fixed only on a non-retry termination
// - retried delayed requests may complete in any mutual order
// - opposite directions are independent and run concurrently
// - posted write acceptance never waits on a non-posted master cycle
// - posted writes are accepted whatever the delayed queue state
// - posted writes leave in arrival order
// - delayed read waits for earlier same-direction posted writes
// - read completion waits for earlier posted writes in its direction
// - delayed write waits for earlier same-direction posted writes
// - fair arbiter between posted queue and delayed queue
// - delayed requests and completions pass freely; write completions pass posted
`timescale 1ns/1ps
`include "order_defs.svh"
module bridge_order #(
  parameter int PW_DEPTH = `PW_DEPTH,
  parameter int DTQ_DEPTH = `DTQ_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // bridge as target, index 0 primary, 1 secondary
  input wire logic [1:0] tgt_req_valid,
  input order_pkg::txn_s [1:0] tgt_req,
  output order_pkg::rsp_s [1:0] tgt_rsp,
  // bridge as master, same indexing
  output logic [1:0] mst_req_valid,
  output order_pkg::txn_s [1:0] mst_req,
  input wire logic [1:0] mst_req_ready,
  input wire logic [1:0] mst_done,
  input order_pkg::cpl_s [1:0] mst_cpl
);
  import order_pkg::*;

  localparam int TXN_W = $bits(txn_s);

  // cross-direction views, direction d starts on bus d
  logic pw_pop [2];
  logic [`PW_CNT_W-1:0] pw_cnt [2];
  logic sk_valid [2];
  txn_s sk_out [2];
  rsp_s rsp_q [2];

  // direction 0 targets the secondary bus, direction 1 the primary
  assign mst_req_valid = {sk_valid[0], sk_valid[1]};
  assign mst_req = {sk_out[0], sk_out[1]};
  assign tgt_rsp = {rsp_q[1], rsp_q[0]};

  function automatic logic is_posted(input logic [`CMD_W-1:0] cmd);
    return (cmd == `CMD_MEM_WR) || (cmd == `CMD_MEM_WRI);
  endfunction

  function automatic logic is_dly_wr(input logic [`CMD_W-1:0] cmd);
    return (cmd == `CMD_IO_WR) || (cmd == `CMD_CFG_WR);
  endfunction

  // both directions are identical and share nothing but posted queue occupancy counts and pop strobes
  for (genvar d = 0; d < 2; d++) begin : g_dir
    localparam int TB = 1 - d;

    typedef struct packed {
      ent_s [DTQ_DEPTH-1:0] ent;
      rsp_s rsp;
      logic busy;
      logic posted;
      logic [`DTQ_IDX_W-1:0] slot;
      logic pref_dly;
    } st_s;

    st_s st_reg, st_next;
    logic pw_push, pw_in_ready, pw_out_valid;
    txn_s pw_head;
    logic sk_push, sk_in_ready;
    txn_s sk_data;

    // posted write leaves its queue only once the target bus has finished it
    assign pw_pop[d] = st_reg.busy && st_reg.posted && mst_done[TB];
    assign rsp_q[d] = st_reg.rsp;

    pw_fifo #(
      .W(TXN_W),
      .DEPTH(PW_DEPTH),
      .CNT_W(`PW_CNT_W)
    ) u_pw (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_valid(pw_push),
      .in_ready(pw_in_ready),
      .in_data(tgt_req[d]),
      .out_valid(pw_out_valid),
      .out_ready(pw_pop[d]),
      .out_data(pw_head),
      .count(pw_cnt[d])
    );

    skid_buf #(
      .W(TXN_W)
    ) u_skid (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_valid(sk_push),
      .in_ready(sk_in_ready),
      .in_data(sk_data),
      .out_valid(sk_valid[d]),
      .out_ready(mst_req_ready[TB]),
      .out_data(sk_out[d])
    );

    always_comb begin
      logic hit, has_free, dly_ok, gnt_dly, gnt_pw;
      logic [`DTQ_IDX_W-1:0] hit_i, free_i, dly_i;
      st_next = st_reg;
      hit = 1'b0;
      has_free = 1'b0;
      dly_ok = 1'b0;
      gnt_dly = 1'b0;
      gnt_pw = 1'b0;
      hit_i = '0;
      free_i = '0;
      dly_i = '0;
      pw_push = 1'b0;
      sk_push = 1'b0;
      sk_data = pw_head;
      st_next.rsp.valid = 1'b0;
      st_next.rsp.kind = RSP_RETRY;
      st_next.rsp.abort = 1'b0;
      st_next.rsp.data = '0;

      // count down earlier posted writes still ahead of each entry
      for (int i = 0; i < DTQ_DEPTH; i++) begin
        if (st_reg.ent[i].st == ENT_WAIT && pw_pop[d] && st_reg.ent[i].ahead != '0) begin
          st_next.ent[i].ahead = st_reg.ent[i].ahead - 1'b1;
        end
        if (st_reg.ent[i].st == ENT_DONE && pw_pop[TB] && st_reg.ent[i].ahead != '0) begin
          st_next.ent[i].ahead = st_reg.ent[i].ahead - 1'b1;
        end
      end

      // answer from the target bus for the cycle in flight
      if (st_reg.busy && mst_done[TB]) begin
        st_next.busy = 1'b0;
        if (!st_reg.posted) begin
          st_next.ent[st_reg.slot].st = ENT_DONE;
          st_next.ent[st_reg.slot].cpl = mst_cpl[TB];
          // read data must trail posted writes heading the same way
          if (st_reg.ent[st_reg.slot].is_rd) begin
            st_next.ent[st_reg.slot].ahead = pw_cnt[TB] - `PW_CNT_W'(pw_pop[TB]);
          end else begin
            st_next.ent[st_reg.slot].ahead = '0;
          end
        end
      end

      // request from the initiator bus
      if (tgt_req_valid[d]) begin
        st_next.rsp.valid = 1'b1;
        if (is_posted(tgt_req[d].cmd)) begin
          // only queue space matters, never delayed progress
          if (pw_in_ready) begin
            pw_push = 1'b1;
            st_next.rsp.kind = RSP_ACCEPT;
          end
        end else begin
          for (int i = DTQ_DEPTH - 1; i >= 0; i--) begin
            if (st_reg.ent[i].st != ENT_FREE &&
                st_reg.ent[i].txn.cmd == tgt_req[d].cmd &&
                st_reg.ent[i].txn.addr == tgt_req[d].addr &&
                st_reg.ent[i].txn.be == tgt_req[d].be) begin
              hit = 1'b1;
              hit_i = `DTQ_IDX_W'(i);
            end
            if (st_reg.ent[i].st == ENT_FREE) begin
              has_free = 1'b1;
              free_i = `DTQ_IDX_W'(i);
            end
          end
          if (hit) begin
            if (st_reg.ent[hit_i].st == ENT_DONE && st_reg.ent[hit_i].ahead == '0) begin
              // only this termination fixes the ordering slot
              st_next.rsp.kind = RSP_DONE;
              st_next.rsp.abort = st_reg.ent[hit_i].cpl.abort;
              st_next.rsp.data = st_reg.ent[hit_i].cpl.data;
              st_next.ent[hit_i].st = ENT_FREE;
            end
          end else if (has_free) begin
            st_next.ent[free_i].st = ENT_WAIT;
            st_next.ent[free_i].txn = tgt_req[d];
            st_next.ent[free_i].is_rd = !is_dly_wr(tgt_req[d].cmd);
            st_next.ent[free_i].ahead = pw_cnt[d] - `PW_CNT_W'(pw_pop[d]);
            st_next.ent[free_i].cpl = '0;
          end
        end
      end

      // pick the next target bus cycle, one in flight at a time
      if (!st_reg.busy && sk_in_ready) begin
        // lowest free-to-go entry wins; delayed entries need no mutual order
        for (int i = DTQ_DEPTH - 1; i >= 0; i--) begin
          if (st_reg.ent[i].st == ENT_WAIT && st_reg.ent[i].ahead == '0) begin
            dly_ok = 1'b1;
            dly_i = `DTQ_IDX_W'(i);
          end
        end
        gnt_dly = dly_ok && (!pw_out_valid || st_reg.pref_dly);
        gnt_pw = pw_out_valid && !gnt_dly;
        if (gnt_pw) begin
          sk_push = 1'b1;
          sk_data = pw_head;
          st_next.busy = 1'b1;
          st_next.posted = 1'b1;
          st_next.pref_dly = 1'b1;
        end else if (gnt_dly) begin
          sk_push = 1'b1;
          sk_data = st_reg.ent[dly_i].txn;
          st_next.busy = 1'b1;
          st_next.posted = 1'b0;
          st_next.slot = dly_i;
          st_next.pref_dly = 1'b0;
          st_next.ent[dly_i].st = ENT_BUSY;
        end
      end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        st_reg <= '0;
        st_reg.rsp.kind <= RSP_RETRY;
        for (int i = 0; i < DTQ_DEPTH; i++) begin
          st_reg.ent[i].st <= ENT_FREE;
        end
      end else begin
        st_reg <= st_next;
      end
    end
  end
endmodule // bridge_order

// >>> core/order_defs.svh
`ifndef ORDER_DEFS_SVH
`define ORDER_DEFS_SVH

// bus command codes as carried on the parallel bus
`define CMD_IO_RD 4'h2
`define CMD_IO_WR 4'h3
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define CMD_CFG_RD 4'hA
`define CMD_CFG_WR 4'hB
`define CMD_MEM_RD_MULT 4'hC
`define CMD_MEM_RD_LINE 4'hE
`define CMD_MEM_WRI 4'hF

// queue sizes, per direction
`define PW_DEPTH 4
`define PW_CNT_W 3
`define DTQ_DEPTH 4
`define DTQ_IDX_W 2

// field widths
`define ADDR_W 32
`define DATA_W 32
`define BE_W 4
`define CMD_W 4

`endif

// >>> core/order_pkg.sv
package order_pkg;
  `include "order_defs.svh"

  typedef struct packed {
    logic [`CMD_W-1:0] cmd;
    logic [`ADDR_W-1:0] addr;
    logic [`BE_W-1:0] be;
    logic [`DATA_W-1:0] data;
  } txn_s;

  typedef enum logic [2:0] {
    RSP_ACCEPT = 3'b001,
    RSP_RETRY = 3'b010,
    RSP_DONE = 3'b100
  } rsp_e;

  typedef struct packed {
    logic valid;
    rsp_e kind;
    logic abort;
    logic [`DATA_W-1:0] data;
  } rsp_s;

  typedef struct packed {
    logic abort;
    logic [`DATA_W-1:0] data;
  } cpl_s;

  typedef enum logic [3:0] {
    ENT_FREE = 4'b0001,
    ENT_WAIT = 4'b0010,
    ENT_BUSY = 4'b0100,
    ENT_DONE = 4'b1000
  } ent_e;

  typedef struct packed {
    ent_e st;
    logic is_rd;
    logic [`PW_CNT_W-1:0] ahead;
    txn_s txn;
    cpl_s cpl;
  } ent_s;
endpackage

// >>> core/pw_fifo.sv
`timescale 1ns/1ps
module pw_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4,
  parameter int CNT_W = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [CNT_W-1:0] count
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CNT_W-1:0] wp;
    logic [CNT_W-1:0] rp;
    logic [CNT_W-1:0] cnt;
  } st_s;

  st_s st_reg, st_next;
  logic push, pop;

  assign in_ready = st_reg.cnt != CNT_W'(DEPTH);
  assign out_valid = st_reg.cnt != '0;
  assign out_data = st_reg.mem[st_reg.rp];
  assign count = st_reg.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // one entry per transaction, entries are never merged
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == CNT_W'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == CNT_W'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // pw_fifo

// >>> core/skid_buf.sv
`timescale 1ns/1ps
module skid_buf #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic mv;
    logic [W-1:0] md;
    logic sv;
    logic [W-1:0] sd;
  } st_s;

  st_s st_reg, st_next;

  // ready comes from a flop so the source never sees a combinational path
  assign in_ready = !st_reg.sv;
  assign out_valid = st_reg.mv;
  assign out_data = st_reg.md;

  always_comb begin
    st_next = st_reg;
    if (st_reg.mv && out_ready) begin
      if (st_reg.sv) begin
        st_next.md = st_reg.sd;
        st_next.sv = 1'b0;
      end else begin
        st_next.mv = 1'b0;
      end
    end
    if (in_valid && !st_reg.sv) begin
      if (!st_next.mv) begin
        st_next.mv = 1'b1;
        st_next.md = in_data;
      end else begin
        st_next.sv = 1'b1;
        st_next.sd = in_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // skid_buf

// >>> testbench/far_target.sv
`timescale 1ns/1ps
module far_target (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // pace
  input wire logic slow,
  // bus cycle request
  input wire logic req_valid,
  input order_pkg::txn_s req,
  output logic ready,
  output logic done,
  output order_pkg::cpl_s cpl
);
  import order_pkg::*;
  txn_s log[$];
  txn_s cur;
  logic busy;
  int wait_cnt;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ready <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
      wait_cnt <= 0;
      cpl <= '0;
    end else begin
      ready <= 1'b0;
      done <= 1'b0;
      // idle data toggles so nothing stale passes for a completion
      cpl.data <= ~cpl.data;
      if (busy) begin
        if (wait_cnt == 0) begin
          done <= 1'b1;
          cpl <= {1'b0, ~cur.addr};
          busy <= 1'b0;
          wait_cnt <= slow ? 4 : 0;
        end else wait_cnt <= wait_cnt - 1;
      end else if (req_valid && ready) begin
        log.push_back(req);
        cur <= req;
        busy <= 1'b1;
        wait_cnt <= slow ? 6 : 1;
      end else if (req_valid) begin
        // acceptance never hangs on other traffic
        if (wait_cnt == 0) ready <= 1'b1;
        else wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule // far_target

// >>> testbench/order_asserts.sv
`include "order_defs.svh"
`timescale 1ns/1ps
module order_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // target side
  input wire logic [1:0] tgt_req_valid,
  input order_pkg::txn_s [1:0] tgt_req,
  input order_pkg::rsp_s [1:0] tgt_rsp,
  // master side
  input wire logic [1:0] mst_req_valid,
  input order_pkg::txn_s [1:0] mst_req,
  input wire logic [1:0] mst_req_ready,
  input wire logic [1:0] mst_done,
  input order_pkg::cpl_s [1:0] mst_cpl
);
  import order_pkg::*;
  logic [3:0] pend_reg;
  logic last_post_reg;
  function automatic logic posted(logic [3:0] c);
    return c == `CMD_MEM_WR || c == `CMD_MEM_WRI;
  endfunction
  // posted writes of direction 0 to 1 still owed; zero means an empty queue
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= 4'h0;
      last_post_reg <= 1'b0;
    end else begin
      pend_reg <= pend_reg + 4'(tgt_rsp[0].valid && tgt_rsp[0].kind == RSP_ACCEPT)
        - 4'(mst_done[1] && last_post_reg);
      if (mst_req_valid[1] && mst_req_ready[1]) begin
        last_post_reg <= posted(mst_req[1].cmd);
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_rsp_next0: assert property (tgt_req_valid[0] |=> tgt_rsp[0].valid)
    else $error("bus0 attempt left unanswered");
  a_rsp_next1: assert property (tgt_req_valid[1] |=> tgt_rsp[1].valid)
    else $error("bus1 attempt left unanswered");
  a_rsp_cause: assert property (tgt_rsp[1].valid |-> $past(tgt_req_valid[1]))
    else $error("bus1 answer without attempt");
  a_delayed_no_accept: assert property (tgt_req_valid[0] && !posted(tgt_req[0].cmd)
    |=> tgt_rsp[0].kind != RSP_ACCEPT) else $error("delayed request taken as posted");
  a_posted_no_done: assert property (tgt_req_valid[1] && posted(tgt_req[1].cmd)
    |=> tgt_rsp[1].kind != RSP_DONE) else $error("posted write answered as delayed");
  a_posted_taken: assert property (tgt_req_valid[0] && posted(tgt_req[0].cmd) && pend_reg == 0
    |=> tgt_rsp[0].kind == RSP_ACCEPT) else $error("posted write refused on empty queue");
  a_req_holds: assert property (mst_req_valid[1] && !mst_req_ready[1]
    |=> mst_req_valid[1] && $stable(mst_req[1])) else $error("bus1 request changed before take");
  a_one_outstanding: assert property (mst_req_valid[1] && mst_req_ready[1]
    |=> !mst_req_valid[1]) else $error("bus1 request issued while one outstanding");
endmodule // order_asserts

bind bridge_order order_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .tgt_req_valid(tgt_req_valid), .tgt_req(tgt_req), .tgt_rsp(tgt_rsp),
  .mst_req_valid(mst_req_valid), .mst_req(mst_req), .mst_req_ready(mst_req_ready),
  .mst_done(mst_done), .mst_cpl(mst_cpl));

// >>> testbench/tb_top.sv
`include "order_defs.svh"
`timescale 1ns/1ps
module tb_top;
  import order_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] tgt_req_valid = 2'h0;
  logic [1:0] slow = 2'h0;
  txn_s [1:0] tgt_req = '0;
  rsp_s [1:0] tgt_rsp;
  logic [1:0] mst_req_valid;
  // one bit per partner instance, so these are nets
  wire [1:0] mst_req_ready, mst_done;
  txn_s [1:0] mst_req;
  wire cpl_s [1:0] mst_cpl;
  int error_cnt = 0;
  int checks = 0;
  always #5 clk_sys = ~clk_sys;
  bridge_order u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .tgt_req_valid(tgt_req_valid),
    .tgt_req(tgt_req), .tgt_rsp(tgt_rsp), .mst_req_valid(mst_req_valid), .mst_req(mst_req),
    .mst_req_ready(mst_req_ready), .mst_done(mst_done), .mst_cpl(mst_cpl));
  far_target u_far0 (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow[0]),
    .req_valid(mst_req_valid[0]), .req(mst_req[0]), .ready(mst_req_ready[0]),
    .done(mst_done[0]), .cpl(mst_cpl[0]));
  far_target u_far1 (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow[1]),
    .req_valid(mst_req_valid[1]), .req(mst_req[1]), .ready(mst_req_ready[1]),
    .done(mst_done[1]), .cpl(mst_cpl[1]));
  function automatic txn_s mk(logic [3:0] c, logic [31:0] a, logic [3:0] be, logic [31:0] d);
    return {c, a, be, d};
  endfunction
  task automatic chk(string what, logic [71:0] exp, logic [71:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hit(int b, txn_s t, output rsp_s r);
    @(posedge clk_sys);
    tgt_req_valid[b] <= 1'b1;
    tgt_req[b] <= t;
    @(posedge clk_sys);
    tgt_req_valid[b] <= 1'b0;
    @(negedge clk_sys);
    r = tgt_rsp[b];
    chk("answer valid", 1, r.valid);
  endtask
  task automatic until_done(int b, txn_s t, output rsp_s r);
    int n;
    r = '0;
    for (n = 0; n < 60 && r.kind !== RSP_DONE; n++) hit(b, t, r);
    chk("final kind", RSP_DONE, r.kind);
  endtask
  task automatic t_posted_stream();
    txn_s sent[$];
    txn_s t, prev;
    int i, rty;
    rty = 0;
    slow[1] <= 1'b1;
    // one address, one lane each: nothing may be merged or dropped
    for (i = 0; i <= 12; i++) begin
      t = mk(i[0] ? `CMD_MEM_WRI : `CMD_MEM_WR, 32'h0000_0100, 4'h1 << (i % 4), 32'(i));
      @(posedge clk_sys);
      tgt_req_valid[0] <= (i < 12);
      tgt_req[0] <= t;
      @(negedge clk_sys);
      if (i > 0 && tgt_rsp[0].kind === RSP_ACCEPT) sent.push_back(prev);
      if (i > 0 && tgt_rsp[0].kind === RSP_RETRY) rty++;
      prev = t;
    end
    chk("refused when full", 1, rty > 0);
    slow[1] <= 1'b0;
    for (i = 0; i < 400 && u_far1.log.size() < sent.size(); i++) @(posedge clk_sys);
    chk("forwarded count", sent.size(), u_far1.log.size());
    foreach (sent[k]) chk("forwarded write", sent[k], u_far1.log[k]);
  endtask
  task automatic t_delayed_all();
    logic [3:0] cmds [7] = '{`CMD_IO_RD, `CMD_IO_WR, `CMD_MEM_RD, `CMD_CFG_RD, `CMD_CFG_WR,
      `CMD_MEM_RD_MULT, `CMD_MEM_RD_LINE};
    rsp_s r;
    txn_s t;
    int b;
    foreach (cmds[i]) begin
      b = i % 2;
      t = mk(cmds[i], 32'h0000_2000 + 32'(i * 16), 4'hF, 32'hA5A5_0000 + 32'(i));
      hit(b, t, r);
      chk("first kind", RSP_RETRY, r.kind);
      until_done(b, t, r);
      chk("forwarded", t, b ? u_far0.log[$] : u_far1.log[$]);
      chk("no abort", 0, r.abort);
      if (!cmds[i][0]) chk("read data", {40'h0, ~t.addr}, {40'h0, r.data});
    end
  endtask
  task automatic t_read_after_post();
    rsp_s r;
    txn_s a, rd, c, bb;
    u_far0.log.delete();
    u_far1.log.delete();
    a = mk(`CMD_MEM_WR, 32'h0000_0300, 4'hF, 32'h0000_1111);
    rd = mk(`CMD_MEM_RD, 32'h0000_0300, 4'hF, 32'h0);
    c = mk(`CMD_MEM_WR, 32'h0000_0400, 4'hF, 32'h0000_3333);
    bb = mk(`CMD_MEM_WR, 32'h0000_0304, 4'hF, 32'h0000_2222);
    slow <= 2'b11;
    hit(0, a, r);
    chk("posted kind", RSP_ACCEPT, r.kind);
    hit(0, rd, r);
    chk("read kind", RSP_RETRY, r.kind);
    // several slow writes the other way so the read data must wait on them
    repeat (3) begin
      hit(1, c, r);
      chk("opposite kind", RSP_ACCEPT, r.kind);
    end
    hit(0, bb, r);
    chk("posted with read pending", RSP_ACCEPT, r.kind);
    slow[1] <= 1'b0;
    until_done(0, rd, r);
    chk("write before read", a, u_far1.log[0]);
    chk("pulled write", c, u_far0.log[0]);
    chk("pulled write done", 0, u_far0.busy);
    chk("pulled writes", 3, u_far0.log.size());
    slow <= 2'b00;
  endtask
  task automatic t_both();
    @(posedge clk_sys);
    tgt_req_valid <= 2'b11;
    tgt_req <= {mk(`CMD_MEM_WR, 32'h0000_0500, 4'hF, 32'h1), mk(`CMD_MEM_WR, 32'h0000_0600, 4'hF, 32'h0)};
    @(posedge clk_sys);
    tgt_req_valid <= 2'b00;
    @(negedge clk_sys);
    chk("bus0 kind", RSP_ACCEPT, tgt_rsp[0].kind);
    chk("bus1 kind", RSP_ACCEPT, tgt_rsp[1].kind);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_posted_stream();
    t_delayed_all();
    t_read_after_post();
    t_both();
    repeat (50) @(posedge clk_sys);
    report_and_stop();
  end
  // the whole run needs under 1500 cycles, well inside the 30000 cycle limit
  initial begin
    #300000;
    error_cnt++;
    report_and_stop();
  end
endmodule // tb_top
